// *** logic/pending_event_index_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module pending_event_index_encoder (
  input  wire logic [31:0] i_pending,
  output logic      [7:0]  o_index,
  output logic      [31:0] o_onehot
);
  import timer_event_pkg::*;

  // Lowest set bit wins; scan from the top so it overrides
  always_comb begin
    o_index  = INDEX_NONE;
    o_onehot = READ_ZERO;
    for (int i = 31; i >= 0; i--) begin
      if (i_pending[i]) begin
        o_index  = 8'(i + 1);
        o_onehot = word_t'(1) << i;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/timer_event_mask_and_raw_status.sv ***
// Operation
// R1 - Each event has a writable enable bit; 1 unmasks, 0 masks; reset zero.
// R2 - Bits 28..24: encoder error, direction change, repeat zero, trigger overflow, fault.
// R3 - Bits 15..12: channel 5 up, channel 4 up, channel 5 down, channel 4 down.
// R4 - Bits 11..8 channel 3..0 up events; bits 7..4 channel 3..0 down events.
// R5 - Bit 1 is counter load event; bit 0 is counter zero event.
// R6 - Raw status shows every pending flag regardless of its enable bit.
// R7 - Raw status is read-only, reads 1 while set, resets zero, at 1090h.
// R8 - Writing 1 to a clear bit clears the raw flag, even when masked.
// R9 - Raw flags stay set until explicitly cleared, for polling software.
// R10 - An illegal quadrature encoder transition sets the encoder error flag.
// R11 - Reserved bits read zero, ignore writes and never raise events.
// R12 - Masked status equals enable mask AND raw status.
// R13 - Writing 1 to a software set bit sets the raw flag, masked if enabled.
// R14 - Pending index reports lowest enabled pending bit plus one, zero when none.
// R15 - A processor read of the index clears that event; debug reads do not.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_event_mask_and_raw_status (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_arst_n,
  // AHB-Lite slave
  input  wire logic                    i_hsel,
  input  wire logic [31:0]             i_haddr,
  input  wire logic [1:0]              i_htrans,
  input  wire logic                    i_hwrite,
  input  wire logic [2:0]              i_hsize,
  input  wire logic [31:0]             i_hwdata,
  input  wire logic                    i_hready,
  input  wire logic                    i_debug_access,
  output logic      [31:0]             o_hrdata,
  output logic                         o_hreadyout,
  output logic                         o_hresp,
  // Event pulses from the timer core
  input  wire logic                    i_zero_event,
  input  wire logic                    i_load_event,
  input  wire logic [5:0]              i_ch_up_event,
  input  wire logic [5:0]              i_ch_down_event,
  input  wire logic                    i_fault_event,
  input  wire logic                    i_trigger_overflow_event,
  input  wire logic                    i_repeat_count_zero_event,
  input  wire logic                    i_direction_change_event,
  // Quadrature encoder pins
  input  wire logic                    i_encoder_enable,
  input  wire logic                    i_encoder_a,
  input  wire logic                    i_encoder_b,
  // State views
  output timer_event_pkg::word_t       o_event_enable_mask,
  output timer_event_pkg::word_t       o_raw_event_status,
  output timer_event_pkg::word_t       o_masked_event_status,
  output logic      [7:0]              o_pending_event_index
);
  import timer_event_pkg::*;

  word_t              event_enable_mask;
  word_t              raw_event_status;
  word_t              next_event_enable_mask;
  word_t              next_raw_event_status;
  logic               wr_pending;
  logic [ADDR_W-1:0]  wr_addr;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  word_t              masked_view;
  logic [7:0]         index_view;

  // Address phase decode
  wire logic              addr_valid  = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  wire logic              rd_request  = addr_valid & ~i_hwrite;
  wire logic              wr_request  = addr_valid & i_hwrite;
  wire logic [ADDR_W-1:0] rd_addr     = i_haddr[ADDR_W-1:0];
  wire logic              rd_index    = rd_request & (rd_addr == OFS_PENDING_INDEX);
  wire logic              rd_mask     = rd_request & (rd_addr == OFS_ENABLE_MASK);
  wire logic              rd_raw      = rd_request & (rd_addr == OFS_RAW_STATUS);
  wire logic              rd_masked   = rd_request & (rd_addr == OFS_MASKED_STATUS);

  // Data phase write decode
  wire logic              wr_mask     = wr_pending & (wr_addr == OFS_ENABLE_MASK);
  wire logic              wr_set      = wr_pending & (wr_addr == OFS_SOFTWARE_SET);
  wire logic              wr_clear    = wr_pending & (wr_addr == OFS_EVENT_CLEAR);
  wire word_t             wdata_evt   = i_hwdata & EVENT_BITS;                             // [R11]

  // Encoder pins cross from outside; two stages before any use
  logic [1:0] enc_meta;
  logic [1:0] enc_sync;
  logic [1:0] enc_prev;
  logic [2:0] enc_armed;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enc_meta <= 2'h0;
      enc_sync <= 2'h0;
    end else begin
      enc_meta <= {i_encoder_b, i_encoder_a};
      enc_sync <= enc_meta;
    end
  end

  // Armed only once sync stages and history hold real pin samples;
  // pins high through a reset would otherwise look like a double step
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enc_prev  <= 2'h0;
      enc_armed <= 3'h0;
    end else begin
      enc_prev  <= enc_sync;
      enc_armed <= {enc_armed[1:0], i_encoder_enable};
    end
  end

  // Gray sequence allows one phase to move per step; both at once is illegal
  wire logic [1:0] enc_delta         = enc_sync ^ enc_prev;
  wire logic       encoder_error_det = i_encoder_enable & (&enc_armed) & (&enc_delta);   // [R10]

  // Hardware event vector; unused positions stay zero
  word_t hw_events;
  always_comb begin
    hw_events                    = READ_ZERO;                                             // [R11]
    hw_events[BIT_ZERO]          = i_zero_event;                                          // [R5]
    hw_events[BIT_LOAD]          = i_load_event;                                          // [R5]
    for (int c = 0; c < CAPTURE_CHANNELS; c++) begin
      hw_events[BIT_CH_UP_BASE + c]   = i_ch_up_event[c];                                 // [R4]
      hw_events[BIT_CH_DOWN_BASE + c] = i_ch_down_event[c];                               // [R4]
    end
    hw_events[BIT_CH5_UP]        = i_ch_up_event[5];                                      // [R3]
    hw_events[BIT_CH4_UP]        = i_ch_up_event[4];                                      // [R3]
    hw_events[BIT_CH5_DOWN]      = i_ch_down_event[5];                                    // [R3]
    hw_events[BIT_CH4_DOWN]      = i_ch_down_event[4];                                    // [R3]
    hw_events[BIT_FAULT]         = i_fault_event;                                         // [R2]
    hw_events[BIT_TRIG_OVERFLOW] = i_trigger_overflow_event;                              // [R2]
    hw_events[BIT_REPEAT_ZERO]   = i_repeat_count_zero_event;                             // [R2]
    hw_events[BIT_DIR_CHANGE]    = i_direction_change_event;                              // [R2]
    hw_events[BIT_ENCODER_ERROR] = encoder_error_det;                                     // [R2] [R10]
  end

  // Register state after the pending bus write; reads see it, avoiding stale data
  wire word_t mask_after_wr = wr_mask ? wdata_evt : event_enable_mask;                    // [R1]
  wire word_t clear_bits    = wr_clear ? wdata_evt : READ_ZERO;                           // [R8]
  wire word_t set_bits      = wr_set ? wdata_evt : READ_ZERO;                             // [R13]
  wire word_t raw_after_wr  = (raw_event_status & ~clear_bits) | set_bits;                // [R8] [R13]
  wire word_t masked_now    = raw_after_wr & mask_after_wr;                               // [R12]

  // Index priority
  logic [7:0] index_now;
  word_t      index_onehot;

  pending_event_index_encoder u_index (
    .i_pending (masked_now),
    .o_index   (index_now),
    .o_onehot  (index_onehot)
  );

  // Only a processor read consumes the reported event
  wire logic  index_consume = rd_index & ~i_debug_access;                                 // [R15]
  wire word_t consume_bits  = index_consume ? index_onehot : READ_ZERO;                   // [R15]

  // Flags hold until cleared; a new hardware event beats any clear of the same cycle
  always_comb begin
    next_event_enable_mask = mask_after_wr & EVENT_BITS;                                  // [R1] [R11]
    next_raw_event_status  = ((raw_after_wr & ~consume_bits) | hw_events) & EVENT_BITS;   // [R9] [R6]
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      event_enable_mask <= RESET_ENABLE_MASK;                                             // [R1]
      raw_event_status  <= RESET_RAW_STATUS;                                              // [R7]
    end else begin
      event_enable_mask <= next_event_enable_mask;
      raw_event_status  <= next_raw_event_status;
    end
  end

  // Read mux; write-only and unmapped words read zero
  wire word_t rd_data =
      rd_index  ? {24'h000000, index_now} :                                               // [R14]
      rd_mask   ? mask_after_wr :                                                         // [R1]
      rd_raw    ? raw_after_wr :                                                          // [R6] [R7]
      rd_masked ? masked_now :                                                            // [R12]
                  READ_ZERO;                                                              // [R11]

  // Zero wait state slave; response is always OKAY
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
      hrdata     <= READ_ZERO;
      hreadyout  <= 1'b1;
      hresp      <= HRESP_OKAY;
    end else begin
      wr_pending <= wr_request;
      wr_addr    <= i_haddr[ADDR_W-1:0];
      hrdata     <= rd_request ? rd_data : READ_ZERO;
      hreadyout  <= 1'b1;
      hresp      <= HRESP_OKAY;
    end
  end

  // Masked view built from next state so it always equals mask AND raw; index lags one cycle
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      masked_view <= READ_ZERO;
      index_view  <= INDEX_NONE;
    end else begin
      masked_view <= next_event_enable_mask & next_raw_event_status;                      // [R12]
      index_view  <= index_now;                                                           // [R14]
    end
  end

  assign o_hrdata              = hrdata;
  assign o_hreadyout           = hreadyout;
  assign o_hresp               = hresp;
  assign o_event_enable_mask   = event_enable_mask;
  assign o_raw_event_status    = raw_event_status;
  assign o_masked_event_status = masked_view;
  assign o_pending_event_index = index_view;

endmodule
`default_nettype wire

// *** logic/timer_event_pkg.sv ***
`default_nettype none
package timer_event_pkg;

  // Byte offsets inside the peripheral window
  localparam int unsigned   ADDR_W             = 13;
  localparam logic [12:0]   OFS_PENDING_INDEX  = 13'h1080;
  localparam logic [12:0]   OFS_ENABLE_MASK    = 13'h1088;
  localparam logic [12:0]   OFS_RAW_STATUS     = 13'h1090;
  localparam logic [12:0]   OFS_MASKED_STATUS  = 13'h1098;
  localparam logic [12:0]   OFS_SOFTWARE_SET   = 13'h10A0;
  localparam logic [12:0]   OFS_EVENT_CLEAR    = 13'h10A8;

  // Event bit positions, shared by every event register
  localparam int unsigned   BIT_ZERO           = 0;
  localparam int unsigned   BIT_LOAD           = 1;
  localparam int unsigned   BIT_CH_DOWN_BASE   = 4;
  localparam int unsigned   BIT_CH_UP_BASE     = 8;
  localparam int unsigned   BIT_CH4_DOWN       = 12;
  localparam int unsigned   BIT_CH5_DOWN       = 13;
  localparam int unsigned   BIT_CH4_UP         = 14;
  localparam int unsigned   BIT_CH5_UP         = 15;
  localparam int unsigned   BIT_FAULT          = 24;
  localparam int unsigned   BIT_TRIG_OVERFLOW  = 25;
  localparam int unsigned   BIT_REPEAT_ZERO    = 26;
  localparam int unsigned   BIT_DIR_CHANGE     = 27;
  localparam int unsigned   BIT_ENCODER_ERROR  = 28;
  localparam int unsigned   CAPTURE_CHANNELS   = 4;

  typedef logic [31:0] word_t;

  localparam word_t         EVENT_BITS         = 32'h1F00FFF3;
  localparam word_t         RESET_ENABLE_MASK  = 32'h00000000;
  localparam word_t         RESET_RAW_STATUS   = 32'h00000000;
  localparam word_t         READ_ZERO          = 32'h00000000;
  localparam logic [7:0]    INDEX_NONE         = 8'h00;

  // AHB-Lite encodings
  localparam logic [1:0]    HTRANS_NONSEQ      = 2'h2;
  localparam logic          HRESP_OKAY         = 1'h0;

endpackage
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_event_pkg::*;
  logic        i_sys_clk, i_arst_n, i_hsel, i_hwrite, i_debug_access, i_zero_event, i_load_event;
  logic        i_fault_event, i_trigger_overflow_event, i_repeat_count_zero_event, i_direction_change_event;
  logic        i_encoder_enable, i_encoder_a, i_encoder_b, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata;
  logic [1:0]  i_htrans;
  logic [5:0]  i_ch_up_event, i_ch_down_event;
  logic [7:0]  o_pending_event_index;
  word_t       o_event_enable_mask, o_raw_event_status, o_masked_event_status, rd, exp;
  wire  [2:0]  i_hsize = 3'h2;
  wire         i_hready = o_hreadyout;
  int          fail_count, cmp_count, i;
  logic [12:0] regs [5] = '{OFS_ENABLE_MASK, OFS_RAW_STATUS, OFS_MASKED_STATUS, OFS_PENDING_INDEX, 13'h1004};
  timer_event_mask_and_raw_status dut (.*);
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input word_t got, input word_t want);
    cmp_count++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait, a stuck hready ends the run
  task automatic edge_rdy;
    int n;
    n = 0;
    @(posedge i_sys_clk);
    while (i_hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        conclude;
      end
      @(posedge i_sys_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [12:0] a, input word_t wd, input logic dbg = 1'b0);
    i_hsel <= 1'b1;
    i_haddr <= {19'h0, a};
    i_hwrite <= wr;
    i_htrans <= HTRANS_NONSEQ;
    i_debug_access <= dbg;
    edge_rdy;
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    edge_rdy;
    rd = o_hrdata;
  endtask
  task automatic rchk(input logic [12:0] a, input word_t want);
    bus(1'b0, a, 32'h0);
    check(rd, want);
  endtask
  task automatic drive_ev(input word_t v);
    i_zero_event <= v[0];
    i_load_event <= v[1];
    i_ch_down_event <= {v[13:12], v[7:4]};
    i_ch_up_event <= {v[15:14], v[11:8]};
    i_fault_event <= v[24];
    i_trigger_overflow_event <= v[25];
    i_repeat_count_zero_event <= v[26];
    i_direction_change_event <= v[27];
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    i_arst_n = 1'b0;
    {i_hsel, i_hwrite, i_debug_access, i_encoder_enable, i_encoder_a, i_encoder_b} = 6'h0;
    {i_haddr, i_hwdata, i_htrans} = 66'h0;
    drive_ev(32'h0);
    repeat (4) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    for (i = 0; i < 5; i++) rchk(regs[i], 32'h0);
    $display("test reset values done");
    bus(1'b1, OFS_ENABLE_MASK, 32'hFFFFFFFF);
    rchk(OFS_ENABLE_MASK, EVENT_BITS);
    bus(1'b1, OFS_ENABLE_MASK, 32'h0);
    bus(1'b1, OFS_RAW_STATUS, 32'hFFFFFFFF);
    rchk(OFS_ENABLE_MASK, 32'h0);
    rchk(OFS_RAW_STATUS, 32'h0);
    $display("test access kinds done");
    // Single bits, so a swapped pair of event lines shows up
    for (i = 0; i < 28; i++) begin
      if (EVENT_BITS[i]) begin
        drive_ev(32'h1 << i);
        @(posedge i_sys_clk);
        drive_ev(32'h0);
        repeat (3) @(posedge i_sys_clk);
        rchk(OFS_RAW_STATUS, 32'h1 << i);
        rchk(OFS_MASKED_STATUS, 32'h0);
        bus(1'b1, OFS_EVENT_CLEAR, 32'h1 << i);
        rchk(OFS_RAW_STATUS, 32'h0);
      end
    end
    $display("test event map done");
    bus(1'b1, OFS_ENABLE_MASK, 32'h12000F03);
    bus(1'b1, OFS_SOFTWARE_SET, 32'hFFFFFFFF);
    rchk(OFS_RAW_STATUS, EVENT_BITS);
    rchk(OFS_MASKED_STATUS, EVENT_BITS & 32'h12000F03);
    bus(1'b0, OFS_PENDING_INDEX, 32'h0, 1'b1);
    check(rd, 32'h1);
    check({24'h0, o_pending_event_index}, 32'h1);
    rchk(OFS_RAW_STATUS, EVENT_BITS);
    exp = EVENT_BITS & 32'h12000F03;
    for (i = 0; i < 32; i++) begin
      if (exp[i]) rchk(OFS_PENDING_INDEX, word_t'(i + 1));
    end
    rchk(OFS_PENDING_INDEX, 32'h0);
    rchk(OFS_RAW_STATUS, EVENT_BITS & ~exp);
    bus(1'b1, OFS_EVENT_CLEAR, 32'hFFFFFFFF);
    rchk(OFS_RAW_STATUS, 32'h0);
    $display("test set and index done");
    i_encoder_enable <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_encoder_a <= 1'b1;
    i_encoder_b <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    rchk(OFS_RAW_STATUS, 32'h1 << BIT_ENCODER_ERROR);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    // Pins still high after reset; wait out the sync stages so a false error shows
    repeat (6) @(posedge i_sys_clk);
    rchk(OFS_RAW_STATUS, 32'h0);
    rchk(OFS_ENABLE_MASK, 32'h0);
    $display("test encoder and reset done");
    conclude;
  end
endmodule
`default_nettype wire

// *** tb/timer_event_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_event_chk (
  input wire logic                   i_sys_clk,
  input wire logic                   i_arst_n,
  input wire logic                   i_hsel,
  input wire logic [31:0]            i_haddr,
  input wire logic [1:0]             i_htrans,
  input wire logic                   i_hwrite,
  input wire logic [31:0]            i_hwdata,
  input wire logic                   i_hready,
  input wire logic                   i_zero_event,
  input wire logic                   i_load_event,
  input wire logic [5:0]             i_ch_up_event,
  input wire logic [5:0]             i_ch_down_event,
  input wire logic                   i_fault_event,
  input wire logic                   i_trigger_overflow_event,
  input wire logic                   i_repeat_count_zero_event,
  input wire logic                   i_direction_change_event,
  input wire logic                   i_encoder_enable,
  input wire logic                   i_encoder_a,
  input wire logic                   i_encoder_b,
  input wire logic [31:0]            o_hrdata,
  input wire logic                   o_hreadyout,
  input wire logic                   o_hresp,
  input wire timer_event_pkg::word_t o_event_enable_mask,
  input wire timer_event_pkg::word_t o_raw_event_status,
  input wire timer_event_pkg::word_t o_masked_event_status
);
  import timer_event_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic  xfer    = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  wire logic  wr_mask = xfer && i_hwrite && (i_haddr[12:0] == OFS_ENABLE_MASK);
  wire logic  rd_raw  = xfer && !i_hwrite && (i_haddr[12:0] == OFS_RAW_STATUS);
  wire word_t hw_ev   = {4'h0, i_direction_change_event, i_repeat_count_zero_event, i_trigger_overflow_event,
                         i_fault_event, 8'h0, i_ch_up_event[5:4], i_ch_down_event[5:4], i_ch_up_event[3:0],
                         i_ch_down_event[3:0], 2'h0, i_load_event, i_zero_event};
  sequence s_mask_write;
    wr_mask ##1 1'b1;
  endsequence
  AST_MASK_WRITE: assert property (s_mask_write |=> o_event_enable_mask == ($past(i_hwdata) & EVENT_BITS))
    else $error("mask write lost");
  AST_EVENT_LOW: assert property (|hw_ev[1:0] |=> ($past(hw_ev[1:0]) & ~o_raw_event_status[1:0]) == 2'h0)
    else $error("zero or load event not latched");
  AST_EVENT_CH: assert property (|hw_ev[15:4] |=> ($past(hw_ev[15:4]) & ~o_raw_event_status[15:4]) == 12'h0)
    else $error("channel event not latched");
  AST_EVENT_HIGH: assert property (|hw_ev[27:24] |=> ($past(hw_ev[27:24]) & ~o_raw_event_status[27:24]) == 4'h0)
    else $error("upper event not latched");
  AST_RAW_HOLD: assert property (|($past(o_raw_event_status) & ~o_raw_event_status) |-> $past(xfer) || $past(xfer, 2))
    else $error("raw flag dropped without a bus access");
  AST_MASKED: assert property (o_masked_event_status == (o_event_enable_mask & o_raw_event_status))
    else $error("masked status wrong");
  AST_RAW_READ: assert property (rd_raw |=> o_hrdata == o_raw_event_status || o_hrdata == $past(o_raw_event_status))
    else $error("raw read data wrong");
  AST_RESERVED: assert property (((o_raw_event_status | o_event_enable_mask) & ~EVENT_BITS) == 32'h0)
    else $error("reserved bit set");
  AST_ENC_ERR: assert property (i_encoder_enable && $past(i_encoder_enable, 4) && $changed(i_encoder_a)
    && $changed(i_encoder_b) |-> ##[1:6] o_raw_event_status[28]) else $error("encoder error not flagged");
  AST_BUS_OKAY: assert property (xfer |=> o_hreadyout && (o_hresp == HRESP_OKAY))
    else $error("bus answer not ready okay");
endmodule
bind timer_event_mask_and_raw_status timer_event_chk u_chk (.*);
`default_nettype wire
